// ### hw/dmaa_pkg.sv
// Shared constants and types for the DMA request sampling and cascade arbiter
package dmaa_pkg;
  localparam int          NCHAN          = 8;
  localparam int          CLK_PERIOD_NS  = 4;
  // One bus state in ns and derived clock count
  localparam int          BUS_STATE_NS   = 8;
  localparam int          BUS_STATE_CYC  = (BUS_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  PHASE_LAST     = 2'(BUS_STATE_CYC - 1);
  localparam logic [1:0]  PHASE_FIRST    = 2'h0;
  // Channels able to serve a cascaded master (4 excluded)
  localparam logic [7:0]  CASC_CAPABLE   = 8'hEF;
  // Grant code that no cascade channel answers to
  localparam logic [2:0]  GRANT_IDLE     = 3'h4;
  // Sampling mode per group after reset: 0 is asynchronous
  localparam logic [1:0]  SYNC_MODE_RST  = 2'h0;
  localparam logic [2:0]  CHAN_RST       = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_HREQ   = 3'h1,
    ST_ARB    = 3'h3,
    ST_XFER   = 3'h2,
    ST_REL    = 3'h6,
    ST_CASC   = 3'h7,
    ST_CDROP  = 3'h5,
    ST_RFSH   = 3'h4
  } dmaa_state_t;

  typedef struct packed {
    dmaa_state_t state;
    logic [1:0]  phase;
    logic [1:0]  sync_mode;
    logic        start_samp;
    logic        samp_req;
    logic        samp_eop;
    logic        last_xfer;
    logic        resume_dma;
    logic        resume_casc;
    logic        casc_again;
    logic [2:0]  chan;
    logic        hold;
    logic [2:0]  grant;
    logic        xfer_go;
    logic        rfsh_go;
    logic        busy;
  } dmaa_regs_t;
endpackage

// ### hw/dmaa_sync.sv
// Two-flop synchroniser for asynchronous request pins
`timescale 1ns/100ps
module dmaa_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] d_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign d_out = sync_ff;
endmodule

// ### hw/dmaa_pick.sv
// Fixed priority picker, lowest channel number wins
`timescale 1ns/100ps
module dmaa_pick (
  input  wire logic [7:0] req,
  output logic            found,
  output logic [2:0]      idx
);
  always_comb begin
    found = 1'b0;
    idx   = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = 3'(i);
      end
    end
  end
endmodule

// ### hw/dmaa_core.sv
// Request sampling, termination, cascade and refresh arbitration for DMA
`timescale 1ns/100ps
// Operation
// [RULE1] Start request captured at bus state begin, acted on at its end.
// [RULE2] End-of-transfer sampling selectable synchronous or asynchronous.
// [RULE3] Sync: sample at end of last requester state; stop ends process.
// [RULE4] Async: sample at each state start, apply at that state's end.
// [RULE5] Async inputs must be valid one clock earlier than sync sampling.
// [RULE6] Async peripheral drops request at start of next-to-last state.
// [RULE7] Sync mode gives the requester one extra bus state to react.
// [RULE8] Pipelined: state where next-address is seen active is commit point.
// [RULE9] Stop seen before next bus cycle begins prevents that transfer.
// [RULE10] Cascade only on channels 0-3 and 5-7.
// [RULE11] Cascade master granted by channel code on encoded grant lines.
// [RULE12] Cascade request arbitrated normally; device idles while master owns bus.
// [RULE13] Cascade ends when master request or host grant goes inactive.
// [RULE14] Refresh has top priority and pre-empts DMA or cascade.
// [RULE15] Refresh after current transfer; interrupted process keeps priority.
// [RULE16] Refresh runs before bus returns to host after final transfer.
// [RULE17] Refresh in cascade: withdraw grant, wait for request to drop.
// [RULE18] Cascaded master drops request once grant is withdrawn.
// [RULE19] Cascade resumes if request returns during refresh, else host.
// [RULE20] Only this device observes the host bus grant.
// [RULE21] Bus hold request raised one bus state after service request.
// [RULE22] Sampling mode set per group by command, asynchronous after reset.
// [RULE23] No new hold request until host grant has dropped.
// [RULE24] Request and end-of-process pass a two-flop synchroniser.
// [RULE25] Idle grant code matches no cascade-capable channel.
module dmaa_core (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [7:0] chan_service_request,
  input  wire logic       process_end_n,
  input  wire logic       next_addr_request_n,
  input  wire logic       host_bus_grant,
  input  wire logic [7:0] chan_enable,
  input  wire logic [7:0] chan_cascade,
  input  wire logic       pipelined,
  input  wire logic       byte_count_done,
  input  wire logic       xfer_access,
  input  wire logic       xfer_last_state,
  input  wire logic       xfer_done,
  input  wire logic       refresh_req,
  input  wire logic       refresh_done,
  input  wire logic       cmd_sync_wr,
  input  wire logic       cmd_group,
  input  wire logic       cmd_sync_mode,
  output logic            host_bus_request,
  output logic [2:0]      encoded_grant_code,
  output logic            xfer_go,
  output logic            refresh_go,
  output logic [2:0]      active_chan,
  output logic            dma_busy,
  output logic            last_transfer
);
  dmaa_pkg::dmaa_regs_t cur_ff;
  dmaa_pkg::dmaa_regs_t nxt_cur;

  logic [7:0] req_s;
  logic       eop_s;
  logic [7:0] req_live;
  logic       pick_found;
  logic [2:0] pick_idx;
  logic       st_begin;
  logic       st_end;
  logic       chan_req;
  logic       req_now;
  logic       eop_now;
  logic       dec_ev;
  logic       stop_now;
  logic       is_casc;

  // Group of a channel is its upper bit
  function automatic logic grp_sync(input logic [1:0] mode, input logic [2:0] ch);
    grp_sync = mode[ch[2]];
  endfunction

  dmaa_sync #(.WIDTH(8)) u_req_sync (  // see [RULE24]
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d_in    (chan_service_request),
    .d_out   (req_s)
  );

  dmaa_sync #(.WIDTH(1)) u_eop_sync (  // see [RULE24]
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d_in    (~process_end_n),
    .d_out   (eop_s)
  );

  assign req_live = req_s & chan_enable;

  dmaa_pick u_pick (
    .req   (req_live),
    .found (pick_found),
    .idx   (pick_idx)
  );

  // Bus state divider
  assign st_begin = (cur_ff.phase == dmaa_pkg::PHASE_FIRST);
  assign st_end   = (cur_ff.phase == dmaa_pkg::PHASE_LAST);
  assign chan_req = req_s[cur_ff.chan];
  assign is_casc  = chan_cascade[pick_idx] & dmaa_pkg::CASC_CAPABLE[pick_idx];  // see [RULE10]

  // Sync mode uses live value at state end, async the value held from state begin
  assign req_now = grp_sync(cur_ff.sync_mode, cur_ff.chan) ? chan_req : cur_ff.samp_req;
  assign eop_now = grp_sync(cur_ff.sync_mode, cur_ff.chan) ? eop_s : cur_ff.samp_eop;
  assign stop_now = ~req_now | eop_now | byte_count_done;  // see [RULE3] [RULE4] [RULE7]

  // Decision point: last requester state, or the next-address state when pipelined
  assign dec_ev = st_end & xfer_access &
                  (pipelined ? ~next_addr_request_n : xfer_last_state);  // see [RULE8] [RULE5]

  always_comb begin
    nxt_cur         = cur_ff;
    nxt_cur.xfer_go = 1'b0;
    nxt_cur.rfsh_go = 1'b0;
    nxt_cur.phase   = st_end ? dmaa_pkg::PHASE_FIRST : 2'(cur_ff.phase + 2'h1);

    if (cmd_sync_wr) begin
      nxt_cur.sync_mode[cmd_group] = cmd_sync_mode;  // see [RULE22] [RULE2]
    end

    // Inputs captured at the start of every bus state
    if (st_begin) begin
      nxt_cur.start_samp = (|req_live) | refresh_req;  // see [RULE1]
      nxt_cur.samp_req   = chan_req;  // see [RULE4]
      nxt_cur.samp_eop   = eop_s;
    end

    unique case (cur_ff.state)
      dmaa_pkg::ST_IDLE: begin
        nxt_cur.grant = dmaa_pkg::GRANT_IDLE;  // see [RULE25]
        nxt_cur.busy  = 1'b0;
        if (st_end && cur_ff.start_samp && !host_bus_grant) begin
          nxt_cur.hold  = 1'b1;  // see [RULE21] [RULE1] [RULE23]
          nxt_cur.busy  = 1'b1;
          nxt_cur.state = dmaa_pkg::ST_HREQ;
        end
      end
      dmaa_pkg::ST_HREQ: begin
        if (st_end && host_bus_grant) begin
          nxt_cur.state = dmaa_pkg::ST_ARB;
        end
      end
      dmaa_pkg::ST_ARB: begin
        // Arbitration in the first state after the grant
        if (!host_bus_grant) begin
          nxt_cur.state = dmaa_pkg::ST_REL;
        end else if (st_end) begin
          nxt_cur.last_xfer   = 1'b0;
          nxt_cur.resume_dma  = 1'b0;
          nxt_cur.resume_casc = 1'b0;
          if (refresh_req) begin
            nxt_cur.rfsh_go = 1'b1;  // see [RULE14]
            nxt_cur.state   = dmaa_pkg::ST_RFSH;
          end else if (!pick_found) begin
            nxt_cur.state = dmaa_pkg::ST_REL;
          end else if (is_casc) begin
            nxt_cur.chan  = pick_idx;
            nxt_cur.grant = pick_idx;  // see [RULE11] [RULE12]
            nxt_cur.state = dmaa_pkg::ST_CASC;
          end else begin
            nxt_cur.chan    = pick_idx;
            nxt_cur.xfer_go = 1'b1;
            nxt_cur.state   = dmaa_pkg::ST_XFER;
          end
        end
      end
      dmaa_pkg::ST_XFER: begin
        if (dec_ev && stop_now) begin
          nxt_cur.last_xfer = 1'b1;  // see [RULE3] [RULE8]
        end
        if (xfer_done) begin
          if (refresh_req) begin
            nxt_cur.rfsh_go    = 1'b1;  // see [RULE15] [RULE16]
            nxt_cur.resume_dma = ~(cur_ff.last_xfer | (dec_ev & stop_now));
            nxt_cur.state      = dmaa_pkg::ST_RFSH;
          end else if (cur_ff.last_xfer || (dec_ev && stop_now)) begin
            nxt_cur.state = dmaa_pkg::ST_REL;
          end
        end else if (st_begin && !xfer_access && !cur_ff.xfer_go) begin
          if (cur_ff.last_xfer || (!grp_sync(cur_ff.sync_mode, cur_ff.chan) && stop_now)) begin
            nxt_cur.state = dmaa_pkg::ST_REL;  // see [RULE9]
          end else begin
            nxt_cur.xfer_go = 1'b1;
          end
        end
      end
      dmaa_pkg::ST_CASC: begin
        // Device stays idle while the cascaded master owns the bus
        if (!chan_req || !host_bus_grant) begin
          nxt_cur.grant = dmaa_pkg::GRANT_IDLE;  // see [RULE13] [RULE25]
          nxt_cur.state = dmaa_pkg::ST_REL;
        end else if (refresh_req) begin
          nxt_cur.grant = dmaa_pkg::GRANT_IDLE;  // see [RULE17] [RULE14]
          nxt_cur.state = dmaa_pkg::ST_CDROP;
        end
      end
      dmaa_pkg::ST_CDROP: begin
        if (!host_bus_grant) begin
          nxt_cur.state = dmaa_pkg::ST_REL;
        end else if (!chan_req) begin
          nxt_cur.rfsh_go     = 1'b1;  // see [RULE17] [RULE18]
          nxt_cur.resume_casc = 1'b1;
          nxt_cur.casc_again  = 1'b0;
          nxt_cur.state       = dmaa_pkg::ST_RFSH;
        end
      end
      dmaa_pkg::ST_RFSH: begin
        if (chan_req && cur_ff.resume_casc) begin
          nxt_cur.casc_again = 1'b1;
        end
        if (refresh_done) begin
          if (cur_ff.resume_casc && (cur_ff.casc_again || chan_req) && host_bus_grant) begin
            nxt_cur.grant = cur_ff.chan;  // see [RULE19]
            nxt_cur.state = dmaa_pkg::ST_CASC;
          end else if (cur_ff.resume_dma && host_bus_grant) begin
            nxt_cur.state = dmaa_pkg::ST_XFER;  // see [RULE15]
          end else begin
            nxt_cur.state = dmaa_pkg::ST_REL;  // see [RULE16] [RULE19]
          end
          nxt_cur.resume_casc = 1'b0;
          nxt_cur.resume_dma  = 1'b0;
        end
      end
      dmaa_pkg::ST_REL: begin
        nxt_cur.hold  = 1'b0;
        nxt_cur.grant = dmaa_pkg::GRANT_IDLE;
        if (!host_bus_grant) begin
          nxt_cur.state = dmaa_pkg::ST_IDLE;  // see [RULE23]
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff.state       <= dmaa_pkg::ST_IDLE;
      cur_ff.phase       <= dmaa_pkg::PHASE_FIRST;
      cur_ff.sync_mode   <= dmaa_pkg::SYNC_MODE_RST;  // see [RULE22]
      cur_ff.start_samp  <= 1'b0;
      cur_ff.samp_req    <= 1'b0;
      cur_ff.samp_eop    <= 1'b0;
      cur_ff.last_xfer   <= 1'b0;
      cur_ff.resume_dma  <= 1'b0;
      cur_ff.resume_casc <= 1'b0;
      cur_ff.casc_again  <= 1'b0;
      cur_ff.chan        <= dmaa_pkg::CHAN_RST;
      cur_ff.hold        <= 1'b0;
      cur_ff.grant       <= dmaa_pkg::GRANT_IDLE;
      cur_ff.xfer_go     <= 1'b0;
      cur_ff.rfsh_go     <= 1'b0;
      cur_ff.busy        <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign host_bus_request   = cur_ff.hold;
  assign encoded_grant_code = cur_ff.grant;
  assign xfer_go            = cur_ff.xfer_go;
  assign refresh_go         = cur_ff.rfsh_go;
  assign active_chan        = cur_ff.chan;
  assign dma_busy           = cur_ff.busy;
  assign last_transfer      = cur_ff.last_xfer;
endmodule

// ### sim/dmaa_core_properties.sv
// Checker for hold, cascade grant and refresh behaviour of the arbiter
`timescale 1ns/100ps
module dmaa_core_properties (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic [7:0] chan_service_request,
  input wire logic [7:0] chan_enable,
  input wire logic [7:0] chan_cascade,
  input wire logic       host_bus_grant,
  input wire logic       refresh_req,
  input wire logic       host_bus_request,
  input wire logic [2:0] encoded_grant_code,
  input wire logic       xfer_go,
  input wire logic       refresh_go
);
  logic req_any;
  logic casc_on;
  assign req_any = |(chan_service_request & chan_enable);
  assign casc_on = encoded_grant_code != dmaa_pkg::GRANT_IDLE;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_hold_latency: assert property (
    $rose(req_any) && !host_bus_request && !host_bus_grant |-> ##[3:6] host_bus_request)
    else $error("hold request not raised in time");
  a_hold_cause: assert property (
    $rose(host_bus_request) |-> $past(req_any, 2) || $past(refresh_req, 2))
    else $error("hold request raised before synchronised request");
  a_rereq_wait: assert property (
    $rose(host_bus_request) |-> !$past(host_bus_grant))
    else $error("hold request raised while host grant high");
  a_go_granted: assert property (
    xfer_go || refresh_go |-> host_bus_grant)
    else $error("cycle started without host grant");
  a_casc_legal: assert property (
    casc_on |-> chan_cascade[encoded_grant_code] && dmaa_pkg::CASC_CAPABLE[encoded_grant_code])
    else $error("grant code names no cascade channel");
  a_casc_owner: assert property (
    casc_on |-> !xfer_go && !refresh_go)
    else $error("cycle started while cascade master owns bus");
  a_casc_release: assert property (
    casc_on && !chan_service_request[encoded_grant_code] |-> ##[1:6] !casc_on)
    else $error("grant kept after cascade request dropped");
  a_refresh_preempt: assert property (
    $rose(refresh_req) && casc_on |-> ##[1:6] !casc_on)
    else $error("grant kept after refresh request");
  c_xfer: cover property (xfer_go);
  c_casc: cover property (casc_on);
  c_rfsh: cover property (refresh_go);
endmodule
bind dmaa_core dmaa_core_properties i_dmaa_core_properties (
  .clk_sys, .rst_b, .chan_service_request, .chan_enable, .chan_cascade, .host_bus_grant,
  .refresh_req, .host_bus_request, .encoded_grant_code, .xfer_go, .refresh_go);

// ### sim/dmaa_host_model.sv
// Host processor and transfer datapath model facing the arbiter
`timescale 1ns/100ps
module dmaa_host_model (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic host_bus_request,
  input  wire logic xfer_go,
  input  wire logic refresh_go,
  output logic      host_bus_grant,
  output logic      xfer_access,
  output logic      xfer_last_state,
  output logic      xfer_done,
  output logic      refresh_done,
  output logic      next_addr_request_n
);
  logic [1:0] gnt_ff;
  logic [2:0] xcnt_ff;
  logic [2:0] rcnt_ff;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gnt_ff  <= 2'h0;
      xcnt_ff <= 3'h0;
      rcnt_ff <= 3'h0;
    end else begin
      // Grant follows hold two clocks late, seen by this device only
      gnt_ff  <= {gnt_ff[0], host_bus_request};
      xcnt_ff <= xfer_go ? 3'h4 : ((xcnt_ff != 3'h0) ? xcnt_ff - 3'h1 : 3'h0);
      rcnt_ff <= refresh_go ? 3'h7 : ((rcnt_ff != 3'h0) ? rcnt_ff - 3'h1 : 3'h0);
    end
  end
  assign host_bus_grant      = gnt_ff[1];
  assign xfer_access         = xcnt_ff != 3'h0;
  assign xfer_last_state     = (xcnt_ff != 3'h0) && (xcnt_ff < 3'h3);
  assign xfer_done           = xcnt_ff == 3'h1;
  assign refresh_done        = rcnt_ff == 3'h1;
  assign next_addr_request_n = xcnt_ff != 3'h3;
endmodule

// ### sim/dma_request_sampling_and_cascade_arbiter_test.sv
// Self-checking bench for the request sampling and cascade arbiter
`timescale 1ns/100ps
module dma_request_sampling_and_cascade_arbiter_test;
  logic       clk_sys, rst_b, process_end_n, pipelined, byte_count_done, refresh_req;
  logic       cmd_sync_wr, cmd_group, cmd_sync_mode, host_bus_grant, xfer_access;
  logic       xfer_last_state, xfer_done, refresh_done, next_addr_request_n;
  logic       host_bus_request, xfer_go, refresh_go, dma_busy, last_transfer;
  logic [7:0] chan_service_request, chan_enable, chan_cascade, h, n_go;
  logic [2:0] encoded_grant_code, active_chan;
  logic [5:0] ev;
  int         error_cnt, cmp_count;
  dmaa_core i_dmaa_core (.clk_sys, .rst_b, .chan_service_request, .process_end_n,
    .next_addr_request_n, .host_bus_grant, .chan_enable, .chan_cascade, .pipelined,
    .byte_count_done, .xfer_access, .xfer_last_state, .xfer_done, .refresh_req,
    .refresh_done, .cmd_sync_wr, .cmd_group, .cmd_sync_mode, .host_bus_request,
    .encoded_grant_code, .xfer_go, .refresh_go, .active_chan, .dma_busy, .last_transfer);
  dmaa_host_model i_dmaa_host_model (.clk_sys, .rst_b, .host_bus_request, .xfer_go,
    .refresh_go, .host_bus_grant, .xfer_access, .xfer_last_state, .xfer_done,
    .refresh_done, .next_addr_request_n);
  assign ev = {!host_bus_request && !host_bus_grant, refresh_go,
    encoded_grant_code == dmaa_pkg::GRANT_IDLE, encoded_grant_code != dmaa_pkg::GRANT_IDLE,
    !host_bus_request, xfer_go};
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_ev(input int k);
    int n;
    n = 0;
    h = 8'h00;
    while (h !== 8'h01 && n < 300) begin
      @(posedge clk_sys);
      #1;
      h = {7'h0, ev[k]};
      n_go = n_go + {7'h0, xfer_go};
      n++;
    end
  endtask
  task automatic rq(input logic [7:0] v);
    @(negedge clk_sys);
    chan_service_request = v;
  endtask
  task automatic idle();
    wait_ev(5);
    repeat (12) @(negedge clk_sys);
    wait_ev(5);
  endtask
  task automatic t_prio_stop();
    rq(8'h24);
    wait_ev(0);
    chk(h, 8'h01);
    chk({7'h0, dma_busy}, 8'h01);
    chk({5'h0, active_chan}, 8'h02);
    rq(8'h20);
    n_go = 8'h00;
    wait_ev(1);
    chk(n_go, 8'h00);
    wait_ev(0);
    chk({5'h0, active_chan}, 8'h05);
    rq(8'h00);
    wait_ev(1);
    chk(h, 8'h01);
    idle();
  endtask
  task automatic t_pipe();
    @(negedge clk_sys);
    pipelined = 1'b1;
    rq(8'h01);
    wait_ev(0);
    rq(8'h00);
    n_go = 8'h00;
    wait_ev(1);
    chk(h, 8'h01);
    chk(n_go, 8'h00);
    idle();
    pipelined = 1'b0;
  endtask
  task automatic t_reset();
    rq(8'h01);
    wait_ev(0);
    @(negedge clk_sys);
    rst_b = 1'b0;
    chan_service_request = 8'h00;
    @(negedge clk_sys);
    chk({7'h0, host_bus_request}, 8'h00);
    chk({5'h0, encoded_grant_code}, 8'h04);
    chk({7'h0, dma_busy}, 8'h00);
    chk({7'h0, last_transfer}, 8'h00);
    rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({7'h0, host_bus_request}, 8'h00);
    idle();
  endtask
  task automatic t_sync_eop();
    for (int g = 0; g < 2; g++) begin
      @(negedge clk_sys);
      cmd_sync_wr = 1'b1;
      cmd_group = g[0];
      cmd_sync_mode = 1'b1;
      @(negedge clk_sys);
      cmd_sync_wr = 1'b0;
      rq((g == 0) ? 8'h02 : 8'h40);
      wait_ev(0);
      @(negedge clk_sys);
      process_end_n = 1'b0;
      n_go = 8'h00;
      wait_ev(1);
      chk(n_go, 8'h00);
      rq(8'h00);
      idle();
      process_end_n = 1'b1;
      cmd_sync_wr = 1'b1;
      cmd_sync_mode = 1'b0;
      @(negedge clk_sys);
      cmd_sync_wr = 1'b0;
    end
  endtask
  task automatic t_refresh_dma();
    rq(8'h01);
    wait_ev(0);
    @(negedge clk_sys);
    refresh_req = 1'b1;
    wait_ev(4);
    chk(h, 8'h01);
    @(negedge clk_sys);
    refresh_req = 1'b0;
    wait_ev(0);
    chk({5'h0, active_chan}, 8'h00);
    chk({7'h0, host_bus_request}, 8'h01);
    @(negedge clk_sys);
    refresh_req = 1'b1;
    byte_count_done = 1'b1;
    wait_ev(4);
    chk({7'h0, host_bus_request}, 8'h01);
    chk({7'h0, last_transfer}, 8'h01);
    rq(8'h00);
    refresh_req = 1'b0;
    wait_ev(1);
    chk(h, 8'h01);
    idle();
    byte_count_done = 1'b0;
  endtask
  task automatic t_cascade();
    @(negedge clk_sys);
    chan_cascade = 8'hFF;
    rq(8'h08);
    wait_ev(2);
    chk({5'h0, encoded_grant_code}, 8'h03);
    rq(8'h00);
    wait_ev(3);
    chk(h, 8'h01);
    idle();
    rq(8'h10);
    wait_ev(0);
    chk({5'h0, encoded_grant_code}, 8'h04);
    rq(8'h00);
    idle();
  endtask
  task automatic t_casc_refresh(input logic back);
    rq(8'h20);
    wait_ev(2);
    @(negedge clk_sys);
    refresh_req = 1'b1;
    wait_ev(3);
    chk(h, 8'h01);
    rq(8'h00);
    wait_ev(4);
    chk(h, 8'h01);
    rq({2'h0, back, 5'h00});
    refresh_req = 1'b0;
    wait_ev(back ? 2 : 1);
    chk(h, 8'h01);
    rq(8'h00);
    idle();
  endtask
  task automatic test_done();
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #160000;
    error_cnt++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    chan_service_request = 8'h00;
    chan_enable = 8'hFF;
    chan_cascade = 8'h00;
    process_end_n = 1'b1;
    pipelined = 1'b0;
    byte_count_done = 1'b0;
    refresh_req = 1'b0;
    cmd_sync_wr = 1'b0;
    cmd_group = 1'b0;
    cmd_sync_mode = 1'b0;
    n_go = 8'h00;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    t_prio_stop();
    t_pipe();
    t_reset();
    t_sync_eop();
    t_refresh_dma();
    t_cascade();
    t_casc_refresh(1'b1);
    t_casc_refresh(1'b0);
    test_done();
  end
endmodule
